// >>> tlr_ctrl.sv
// Init sequencer, timing refinements, interrupt and APB register file of the token LAN controller
`timescale 1ns/10ps
// Contract
// - Line-idle wait holds init writes by default
// - Skip option suppresses wait during init routine
// - Own id write stores D1 and id
// - Enhanced timing defaults off, enables refinements
// - Clear or successor read drops interrupt briefly
// - Enhanced: disable time from fixed 20 MHz
// - Enhanced: prescale select synchronised
// - Legacy: command interval from operation clock
// - Enhanced: command interval 100 ns always
// - Legacy: enable commands blocked after status return
// - Receiver inhibited return raises interrupt
// - Enhanced: status returns at pulse end
// - Enhanced: own or probe id write clears lingering match
// - Enhanced: soft reset also clears mask
// - Soft reset on own id zero or bit
// - Soft reset sets status bits high
module tlr_ctrl
#(
    parameter int OPCLK_DIV = tlr_pkg::OPCLK_DIV_DEFAULT
)
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        line_active,
    input  wire logic        tx_done,
    input  wire logic        rx_done,
    input  wire logic        match_hit,
    output logic             interrupt_out_low,
    output logic             irq,
    output logic      [2:0]  prescale_select_bits,
    output logic             probe_match,
    output logic             soft_reset
);
    import tlr_pkg::*;

    localparam int OPW = $clog2(OPCLK_DIV + 1);

    logic [7:0]  config_reg;
    logic [7:0]  own_station_id;
    logic [7:0]  probe_station_id;
    logic [7:0]  dup_station_id;
    logic [7:0]  successor_station_id;
    logic [2:0]  prescale_select;
    logic [2:0]  presc_meta;
    logic [7:0]  ram0;
    logic [7:0]  ram1;
    logic [ST_WIDTH-1:0] status;
    logic [ST_WIDTH-1:0] mask;
    logic        transmitter_available;
    logic        receiver_inhibited;
    tlr_init_t   init_state;
    logic [9:0]  init_cnt;
    logic [OPW-1:0] op_div;
    logic        op_tick;
    logic [3:0]  enh_div;
    logic        enh_tick;
    logic [5:0]  dis_cnt;
    logic [5:0]  cmd_gap;
    logic [3:0]  prohib;
    logic [3:0]  set_pulse;
    logic        set_tx;
    logic        set_rx;
    logic        pend_tx;
    logic        pend_rx;
    logic [3:0]  linger;
    logic        wr_en;
    logic        rd_en;
    logic        enh;
    logic        skip_wait;
    logic        own_wr;
    logic        cmd_wr;
    logic        cmd_ok;
    logic        soft_now;
    logic        irq_clear_ev;
    logic        in_init;
    logic        ri_rise;
    logic        ri_q;
    logic [ST_WIDTH-1:0] events;

    // Bus strobes and decoded write events
    assign wr_en        = psel && penable && pwrite;
    assign rd_en        = psel && penable && !pwrite;
    assign pready       = 1'b1;
    assign enh          = config_reg[CFG_ENH_BIT];
    assign skip_wait    = config_reg[CFG_SKIP_BIT];
    assign own_wr       = wr_en && paddr == OFF_OWN_ID;
    assign cmd_wr       = wr_en && paddr == OFF_COMMAND;
    assign soft_now     = (own_wr && pwdata[7:0] == OWN_ID_SOFTRST)
                        || (wr_en && paddr == OFF_CONFIG && pwdata[CFG_RESET_BIT]);
    assign irq_clear_ev = (cmd_wr && (pwdata[3:0] == CMD_CLR_TXRX || pwdata[3:0] == CMD_CLR_FLAG))
                        || (rd_en && paddr == OFF_SUCC_ID);
    assign in_init      = init_state != TLR_IDLE;

    // Address above the line register answers with an error
    always_comb
    begin
        pslverr = 1'b0;
        if (psel && penable && paddr > OFF_LINE)
            pslverr = 1'b1;
    end

    // Hard-reset configuration; options stay off until written
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            config_reg <= 8'h00;
        else if (wr_en && paddr == OFF_CONFIG)
            config_reg <= {4'h0, pwdata[3:0] & 4'hB}; // Reset bit self-clears
    end

    // Station identity registers
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            own_station_id       <= 8'h00;
            probe_station_id     <= 8'h00;
            dup_station_id       <= 8'h00;
            successor_station_id <= 8'h00;
        end
        else if (wr_en)
        begin
            if (paddr == OFF_OWN_ID)
                own_station_id <= pwdata[7:0];
            if (paddr == OFF_PROBE_ID)
                probe_station_id <= pwdata[7:0];
            if (paddr == OFF_DUP_ID)
                dup_station_id <= pwdata[7:0];
            if (paddr == OFF_SUCC_ID)
                successor_station_id <= pwdata[7:0];
        end
    end

    // Soft reset pulse out
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            soft_reset <= 1'b0;
        else
            soft_reset <= soft_now;
    end

    // Operation clock tick and fixed 20 MHz tick
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            op_div <= '0;
            enh_div <= 4'h0;
        end
        else
        begin
            op_div <= (op_div == OPW'(OPCLK_DIV - 1)) ? '0 : op_div + 1'b1;
            enh_div <= (enh_div == 4'(ENH_DIV_CYC - 1)) ? 4'h0 : enh_div + 4'h1;
        end
    end
    assign op_tick  = op_div == '0;
    assign enh_tick = enh_div == 4'h0;

    // RAM initialisation sequencer after own id write
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            init_state <= TLR_IDLE;
            ram0 <= 8'h00;
            ram1 <= 8'h00;
            init_cnt <= 10'h000;
        end
        else
        begin
            // Deadline counts only once the line lets the routine run
            init_cnt <= (in_init && !(init_state == TLR_WAIT_LINE && line_active && !skip_wait))
                        ? init_cnt + 10'h001 : 10'h000;
            case (init_state)
                TLR_IDLE:
                    if (own_wr && pwdata[7:0] != OWN_ID_SOFTRST)
                        init_state <= TLR_WAIT_LINE;
                TLR_WAIT_LINE:
                    if (!line_active || skip_wait)
                        init_state <= TLR_WR0;
                TLR_WR0:
                begin
                    ram0 <= INIT_MARK;
                    init_state <= TLR_WR1;
                end
                TLR_WR1:
                begin
                    ram1 <= own_station_id;
                    init_state <= TLR_IDLE;
                end
                default:
                    init_state <= TLR_IDLE;
            endcase
        end
    end

    // Prescale select register and optional synchronisers
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            prescale_select <= PRESCALE_RESET;
            presc_meta <= PRESCALE_RESET;
            prescale_select_bits <= PRESCALE_RESET;
        end
        else
        begin
            if (wr_en && paddr == OFF_SPEED)
                prescale_select <= pwdata[2:0]; // Host keeps zero at high rate
            if (op_tick)
                presc_meta <= prescale_select;
            if (!enh)
                prescale_select_bits <= prescale_select;
            else if (op_tick)
                prescale_select_bits <= presc_meta;
        end
    end

    // Command interval timer, legacy on op clock, enhanced on crystal
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            cmd_gap <= 6'h00;
        else if (cmd_wr && cmd_ok)
            cmd_gap <= enh ? 6'(XTAL_INTERVAL_CYC) : 6'(OPCLK_INTERVAL_TICKS);
        else if (cmd_gap != 6'h00 && (enh || op_tick))
            cmd_gap <= cmd_gap - 6'h01;
    end

    // Enable command prohibition after status bit returns (legacy only)
    always_comb
    begin
        cmd_ok = cmd_gap == 6'h00;
        if (!enh && prohib != 4'h0 && (pwdata[3:0] == CMD_EN_TX || pwdata[3:0] == CMD_EN_RX))
            cmd_ok = 1'b0;
    end

    // Internal setting pulse for status bits
    assign set_tx = tx_done || (cmd_wr && cmd_ok && pwdata[3:0] == CMD_DIS_TX);
    assign set_rx = rx_done || (cmd_wr && cmd_ok && pwdata[3:0] == CMD_DIS_RX);
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || soft_now)
        begin
            set_pulse <= 4'h0;
            prohib <= 4'h0;
            pend_tx <= 1'b0;
            pend_rx <= 1'b0;
        end
        else
        begin
            if (set_tx || set_rx)
                set_pulse <= 4'(SET_PULSE_OPCLK_TICKS);
            else if (set_pulse != 4'h0 && op_tick)
                set_pulse <= set_pulse - 4'h1;
            // Which status bit the running pulse returns at its end
            if (set_tx)
                pend_tx <= 1'b1;
            else if (set_pulse == 4'h1 && op_tick)
                pend_tx <= 1'b0;
            if (set_rx)
                pend_rx <= 1'b1;
            else if (set_pulse == 4'h1 && op_tick)
                pend_rx <= 1'b0;
            if (!enh && (set_tx || set_rx))
                prohib <= 4'(PROHIBIT_OPCLK_TICKS);
            else if (prohib != 4'h0 && op_tick)
                prohib <= prohib - 4'h1;
        end
    end

    // Status bits: legacy at pulse start, enhanced at pulse end
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || soft_now)
        begin
            transmitter_available <= 1'b1;
            receiver_inhibited <= 1'b1;
        end
        else
        begin
            if (cmd_wr && cmd_ok && pwdata[3:0] == CMD_EN_TX)
                transmitter_available <= 1'b0;
            else if (set_tx && !enh)
                transmitter_available <= 1'b1;
            else if (enh && set_pulse == 4'h1 && op_tick && pend_tx)
                transmitter_available <= 1'b1;
            if (cmd_wr && cmd_ok && pwdata[3:0] == CMD_EN_RX)
                receiver_inhibited <= 1'b0;
            else if (set_rx && !enh)
                receiver_inhibited <= 1'b1;
            else if (enh && set_pulse == 4'h1 && op_tick && pend_rx)
                receiver_inhibited <= 1'b1;
        end
    end

    // Lingering probe and duplicate match state
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            linger <= 4'h0;
        else if (enh && (own_wr || (wr_en && paddr == OFF_PROBE_ID)))
            linger <= 4'h0;
        else if (match_hit)
            linger <= 4'(PROBE_LINGER_TICKS);
        else if (linger != 4'h0 && op_tick)
            linger <= linger - 4'h1;
    end
    assign probe_match = linger != 4'h0;

    // Sticky event status, write one to clear, set wins
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            ri_q <= 1'b1;
        else
            ri_q <= receiver_inhibited;
    end
    assign ri_rise = receiver_inhibited && !ri_q;
    assign events = {cmd_wr && !cmd_ok, init_state == TLR_WR1, ri_rise, 1'b0,
                     transmitter_available && !status[ST_TX_AVAIL_BIT]};
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            status <= '0;
        else if (wr_en && paddr == OFF_STATUS)
            status <= (status & ~pwdata[ST_WIDTH-1:0]) | events;
        else
            status <= status | events;
    end

    // Mask cleared by hard reset, and soft reset when enhanced
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || (soft_now && enh))
            mask <= '0;
        else if (wr_en && paddr == OFF_MASK)
            mask <= pwdata[ST_WIDTH-1:0];
    end

    // Interrupt disable timer after clear command or successor read
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            dis_cnt <= 6'h00;
        else if (irq_clear_ev && irq)
            dis_cnt <= enh ? 6'(ENH_IRQ_TICKS) : 6'(IRQ_DIS_FAST_CYC);
        else if (dis_cnt != 6'h00 && (enh ? enh_tick : 1'b1))
            dis_cnt <= dis_cnt - 6'h01;
    end

    // Level interrupt output
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            irq <= 1'b0;
        else
            irq <= |(status & mask) && dis_cnt == 6'h00;
    end
    assign interrupt_out_low = !irq;

    // Read data mux
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                OFF_CONFIG:   prdata <= {24'h0, config_reg};
                OFF_STATUS:   prdata <= {24'h0, 3'h0, status} | {30'h0, receiver_inhibited, transmitter_available} << 5;
                OFF_MASK:     prdata <= {27'h0, mask};
                OFF_OWN_ID:   prdata <= {24'h0, own_station_id};
                OFF_PROBE_ID: prdata <= {24'h0, probe_station_id};
                OFF_DUP_ID:   prdata <= {24'h0, dup_station_id};
                OFF_SUCC_ID:  prdata <= {24'h0, successor_station_id};
                OFF_SPEED:    prdata <= {29'h0, prescale_select};
                OFF_RAM0:     prdata <= {24'h0, ram0};
                OFF_RAM1:     prdata <= {24'h0, ram1};
                OFF_LINE:     prdata <= {31'h0, line_active};
                default:      prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Assertions
    init_deadline_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        in_init && !line_active |-> init_cnt < 10'(INIT_LIMIT_CYC)) else $error("init too slow");
    line_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        init_state == TLR_WAIT_LINE && line_active && !skip_wait |=> init_state == TLR_WAIT_LINE)
        else $error("init not held by busy line");
    skip_wait_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        init_state == TLR_WAIT_LINE && skip_wait |=> init_state == TLR_WR0 ##1 ram0 == INIT_MARK)
        else $error("skip did not proceed");
    irq_drop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        irq_clear_ev && irq |=> ##1 !irq [*7]) else $error("interrupt not held off");
    soft_status_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        soft_now |=> transmitter_available && receiver_inhibited) else $error("soft reset status");
    mask_soft_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        soft_now && enh |=> mask == '0) else $error("mask not cleared");
    prohib_block_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !enh && prohib != 4'h0 && cmd_wr && pwdata[3:0] == CMD_EN_RX |=> $stable(receiver_inhibited))
        else $error("enable accepted in prohibition");
    linger_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        enh && own_wr |=> !probe_match) else $error("linger not cleared");
    gap_enh_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        enh && cmd_wr && cmd_ok |=> cmd_gap == 6'(XTAL_INTERVAL_CYC)) else $error("bad interval");
    ri_irq_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ri_rise |=> status[ST_RX_INHIB_BIT]) else $error("ri event lost");
    init_c: cover property (@(posedge sys_clk) init_state == TLR_WR1);
    drop_c: cover property (@(posedge sys_clk) irq_clear_ev && irq);
    soft_c: cover property (@(posedge sys_clk) soft_now && enh);
endmodule

// >>> tlr_pkg.sv
// Package of register offsets, field positions, reset values and timing counts for the refinement block
package tlr_pkg;
    // Clock and timing
    localparam int SYS_CLK_MHZ            = 250;
    localparam int INIT_LIMIT_NS          = 3000;
    localparam int INIT_LIMIT_CYC         = INIT_LIMIT_NS * SYS_CLK_MHZ / 1000;
    localparam int IRQ_DIS_FAST_NS        = 200;
    localparam int IRQ_DIS_FAST_CYC       = (IRQ_DIS_FAST_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int ENH_CLK_MHZ            = 20;
    localparam int ENH_DIV_CYC            = SYS_CLK_MHZ / ENH_CLK_MHZ;
    localparam int ENH_IRQ_TICKS          = 5;
    localparam int XTAL_INTERVAL_NS       = 100;
    localparam int XTAL_INTERVAL_CYC      = (XTAL_INTERVAL_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int OPCLK_INTERVAL_TICKS   = 2;
    localparam int PROHIBIT_OPCLK_TICKS   = 4;
    localparam int SET_PULSE_OPCLK_TICKS  = 4;
    localparam int OPCLK_DIV_DEFAULT      = 50;
    localparam int PROBE_LINGER_TICKS     = 8;

    // Register byte offsets
    localparam logic [7:0] OFF_CONFIG     = 8'h00;
    localparam logic [7:0] OFF_COMMAND    = 8'h04;
    localparam logic [7:0] OFF_STATUS     = 8'h08;
    localparam logic [7:0] OFF_MASK       = 8'h0C;
    localparam logic [7:0] OFF_OWN_ID     = 8'h10;
    localparam logic [7:0] OFF_PROBE_ID   = 8'h14;
    localparam logic [7:0] OFF_DUP_ID     = 8'h18;
    localparam logic [7:0] OFF_SUCC_ID    = 8'h1C;
    localparam logic [7:0] OFF_SPEED      = 8'h20;
    localparam logic [7:0] OFF_RAM0       = 8'h24;
    localparam logic [7:0] OFF_RAM1       = 8'h28;
    localparam logic [7:0] OFF_LINE       = 8'h2C;

    // Configuration fields
    localparam int CFG_SKIP_BIT           = 0;
    localparam int CFG_ENH_BIT            = 1;
    localparam int CFG_RESET_BIT          = 2;
    localparam int CFG_BUSMODE_BIT        = 3;

    // Status fields (status and mask share layout)
    localparam int ST_TX_AVAIL_BIT        = 0;
    localparam int ST_RX_INHIB_BIT        = 2;
    localparam int ST_INIT_DONE_BIT       = 3;
    localparam int ST_CMD_REFUSED_BIT     = 4;
    localparam int ST_WIDTH               = 5;

    // Commands in the low nibble of the command register
    localparam logic [3:0] CMD_CLR_TXRX   = 4'h1;
    localparam logic [3:0] CMD_CLR_FLAG   = 4'h2;
    localparam logic [3:0] CMD_EN_TX      = 4'h3;
    localparam logic [3:0] CMD_EN_RX      = 4'h4;
    localparam logic [3:0] CMD_DIS_TX     = 4'h5;
    localparam logic [3:0] CMD_DIS_RX     = 4'h6;

    // RAM initialisation and reset values
    localparam logic [7:0] INIT_MARK      = 8'hD1;
    localparam logic [7:0] OWN_ID_SOFTRST = 8'h00;
    localparam logic [2:0] PRESCALE_RESET = 3'h0;
    localparam logic [7:0] MASK_RESET     = 8'h00;

    typedef enum logic [1:0] {TLR_IDLE, TLR_WAIT_LINE, TLR_WR0, TLR_WR1} tlr_init_t;
endpackage

// >>> tlr_host.sv
// Host model that drives the APB register bus of the controller
`timescale 1ns/10ps
module tlr_host
(
    input  wire logic        sys_clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic [31:0] rd_data;
    logic        rd_err;
    // Bus idle from time zero
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end
    // One transfer: direction picks write or read strobe, held until pready
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// >>> token_lan_init_and_timing_refinements_tb_top.sv
// Self-checking testbench of the init, timing and interrupt block
`timescale 1ns/10ps
module token_lan_init_and_timing_refinements_tb_top;
    import tlr_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic err;} tlr_row_t;
    logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        line_active, tx_done, rx_done, match_hit;
    logic        interrupt_out_low, irq, probe_match, soft_reset;
    logic [2:0]  prescale_select_bits;
    int          mismatches, cmp_count, cyc, soft_cnt, s0;
    tlr_row_t    rows [7];
    tlr_host host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    tlr_ctrl dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .line_active(line_active), .tx_done(tx_done), .rx_done(rx_done), .match_hit(match_hit),
        .interrupt_out_low(interrupt_out_low), .irq(irq), .prescale_select_bits(prescale_select_bits),
        .probe_match(probe_match), .soft_reset(soft_reset));
    // Clock of 4 ns period
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Hang guard and soft reset pulse counter
    always @(posedge sys_clk)
    begin
        cyc++;
        if (soft_reset === 1'b1)
            soft_cnt++;
        if (cyc == 30000)
        begin
            mismatches++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0);
        chk(nm, e, host.rd_data & m);
    endtask
    task automatic pulse_rx();
        @(posedge sys_clk);
        rx_done <= 1'b1;
        @(posedge sys_clk);
        rx_done <= 1'b0;
    endtask
    // Bounded wait for the interrupt to rise
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 600)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk("irq_raised", 32'h1, {31'h0, irq});
    endtask
    // Checks the interrupt stays dropped for 200 ns after its cause
    task automatic chk_low(input string nm);
        @(posedge sys_clk);
        repeat (49)
        begin
            @(posedge sys_clk);
            if (irq !== 1'b0)
                chk(nm, 32'h0, {31'h0, irq});
        end
    endtask
    // Two command writes with a gap, checks refused flag
    task automatic cmd_pair(input int gap, input logic [31:0] e, input string nm);
        wr(OFF_STATUS, 32'h1F);
        wr(OFF_COMMAND, {28'h0, CMD_DIS_TX});
        repeat (gap) @(posedge sys_clk);
        wr(OFF_COMMAND, {28'h0, CMD_DIS_RX});
        rdc(nm, OFF_STATUS, 32'h10, e);
    endtask
    task automatic results();
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        sys_rst = 1'b1;
        line_active = 1'b0;
        tx_done = 1'b0;
        rx_done = 1'b0;
        match_hit = 1'b0;
        rows = '{'{OFF_MASK, 32'h1F, 32'h1F, 1'b0}, '{OFF_PROBE_ID, 32'hA5, 32'hA5, 1'b0},
            '{OFF_DUP_ID, 32'h5A, 32'h5A, 1'b0}, '{OFF_SPEED, 32'h5, 32'h5, 1'b0},
            '{OFF_CONFIG, 32'h3, 32'h3, 1'b0}, '{OFF_CONFIG, 32'h0, 32'h0, 1'b0}, '{8'h30, 32'h1, 32'h0, 1'b1}};
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        chk("reset_outs", 32'h1, {irq, probe_match, soft_reset, prescale_select_bits, interrupt_out_low});
        rdc("cfg_reset", OFF_CONFIG, 32'h3, 32'h0);
        // Register table: write, error flag, readback
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            chk("pslverr", {31'h0, rows[i].err}, {31'h0, host.rd_err});
            if (!rows[i].err)
                rdc("readback", rows[i].a, 32'hFF, rows[i].e);
        end
        chk("prescale", 32'h5, {29'h0, prescale_select_bits});
        wr(OFF_SPEED, 32'h0);
        // Init held off by a busy line, then done when idle
        line_active <= 1'b1;
        wr(OFF_OWN_ID, 32'h33);
        repeat (INIT_LIMIT_CYC) @(posedge sys_clk);
        host.xfer(1'b0, OFF_RAM1, 32'h0);
        cmp_count++;
        if (host.rd_data[7:0] === 8'h33)
        begin
            mismatches++;
            $display("ERROR ram1_held expected other than 33 seen 33");
        end
        line_active <= 1'b0;
        repeat (INIT_LIMIT_CYC) @(posedge sys_clk);
        rdc("ram0", OFF_RAM0, 32'hFF, {24'h0, INIT_MARK});
        rdc("ram1", OFF_RAM1, 32'hFF, 32'h33);
        wr(OFF_CONFIG, 32'h1);
        line_active <= 1'b1;
        wr(OFF_OWN_ID, 32'h44);
        repeat (INIT_LIMIT_CYC) @(posedge sys_clk);
        rdc("ram1_skip", OFF_RAM1, 32'hFF, 32'h44);
        line_active <= 1'b0;
        // Soft resets: legacy keeps mask, enhanced clears it
        s0 = soft_cnt;
        wr(OFF_CONFIG, 32'h4);
        repeat (4) @(posedge sys_clk);
        chk("soft_bit", s0 + 1, soft_cnt);
        rdc("live_bits", OFF_STATUS, 32'h60, 32'h60);
        rdc("mask_legacy", OFF_MASK, 32'h1F, 32'h1F);
        wr(OFF_CONFIG, 32'h2);
        wr(OFF_OWN_ID, {24'h0, OWN_ID_SOFTRST});
        repeat (4) @(posedge sys_clk);
        chk("soft_id", s0 + 2, soft_cnt);
        rdc("mask_enh", OFF_MASK, 32'h1F, 32'h0);
        // Interrupt drop after each clearing cause, enhanced timing
        wr(OFF_CONFIG, 32'h2);
        wr(OFF_STATUS, 32'h1F);
        wr(OFF_MASK, 32'h4);
        for (int k = 0; k < 3; k++)
        begin
            wr(OFF_STATUS, 32'h1F);
            wr(OFF_COMMAND, {28'h0, CMD_EN_RX});
            pulse_rx();
            wait_irq();
            chk("intr_low", 32'h0, {31'h0, interrupt_out_low});
            if (k == 2)
                host.xfer(1'b0, OFF_SUCC_ID, 32'h0);
            else
                wr(OFF_COMMAND, {28'h0, k == 0 ? CMD_CLR_TXRX : CMD_CLR_FLAG});
            chk_low("irq_dropped");
        end
        wr(OFF_STATUS, 32'h1F);
        wr(OFF_MASK, 32'h0);
        wr(OFF_COMMAND, {28'h0, CMD_EN_RX});
        pulse_rx();
        repeat (600) @(posedge sys_clk);
        chk("irq_masked", 32'h0, {31'h0, irq});
        rdc("ri_event", OFF_STATUS, 32'h4, 32'h4);
        // Enhanced: transmitter bit returns only at pulse end
        wr(OFF_COMMAND, {28'h0, CMD_EN_TX});
        rdc("ta_low", OFF_STATUS, 32'h60, 32'h40);
        @(posedge sys_clk);
        tx_done <= 1'b1;
        @(posedge sys_clk);
        tx_done <= 1'b0;
        rdc("ta_wait", OFF_STATUS, 32'h20, 32'h0);
        repeat (300) @(posedge sys_clk);
        rdc("ta_back", OFF_STATUS, 32'h60, 32'h60);
        // Command spacing in both timing modes
        cmd_pair(0, 32'h10, "cmd_fast");
        repeat (40) @(posedge sys_clk);
        cmd_pair(30, 32'h0, "cmd_enh");
        wr(OFF_CONFIG, 32'h0);
        repeat (300) @(posedge sys_clk);
        cmd_pair(30, 32'h10, "cmd_legacy");
        // Lingering match cleared by a probe id write
        wr(OFF_CONFIG, 32'h2);
        @(posedge sys_clk);
        match_hit <= 1'b1;
        @(posedge sys_clk);
        match_hit <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("match_set", 32'h1, {31'h0, probe_match});
        wr(OFF_PROBE_ID, 32'h12);
        @(posedge sys_clk);
        chk("match_clr", 32'h0, {31'h0, probe_match});
        // Legacy prohibition of enable receive after status return
        wr(OFF_CONFIG, 32'h0);
        repeat (300) @(posedge sys_clk);
        wr(OFF_STATUS, 32'h1F);
        wr(OFF_COMMAND, {28'h0, CMD_EN_RX});
        repeat (110) @(posedge sys_clk);
        pulse_rx();
        wr(OFF_COMMAND, {28'h0, CMD_EN_RX});
        rdc("en_rx_block", OFF_STATUS, 32'h10, 32'h10);
        results();
    end
endmodule
